// file: hdl/configurable_embedded_ram.v
// Configurable embedded RAM block: one of three native sizes, selectable
// port shapes, single, simple dual, true dual (not small), ROM (not large) and FIFO use.
// Assumes port inputs come from logic on sys_clk; no synchronisers.
`timescale 1ns/1ps
`include "embedded_ram_consts.vh"

module configurable_embedded_ram #(
  parameter [1:0] BLOCK_TYPE = `BLK_MEDIUM
) (
  // Clock and reset
  input  wire                 sys_clk,
  input  wire                 nrst,
  // Configuration
  input  wire [2:0]           mode_sel,
  input  wire [`WCODE_W-1:0]  width_a,
  input  wire [`WCODE_W-1:0]  width_b,
  // Port A
  input  wire [`ADDR_W-1:0]   addr_a,
  input  wire                 wen_a,
  input  wire                 ren_a,
  input  wire                 clr_a,
  input  wire [`NATIVE_W(BLOCK_TYPE)-1:0] din_a,
  output wire [`NATIVE_W(BLOCK_TYPE)-1:0] dout_a,
  // Port B
  input  wire [`ADDR_W-1:0]   addr_b,
  input  wire                 wen_b,
  input  wire                 ren_b,
  input  wire                 clr_b,
  input  wire [`NATIVE_W(BLOCK_TYPE)-1:0] din_b,
  output wire [`NATIVE_W(BLOCK_TYPE)-1:0] dout_b,
  // Status
  output wire                 fifo_full,
  output wire                 fifo_empty,
  output wire                 cfg_err
);

  // ****************************************
  // Geometry
  // ****************************************
  // Native size per block type
  localparam W    = `NATIVE_W(BLOCK_TYPE);
  localparam D    = (BLOCK_TYPE == `BLK_SMALL)  ? `SMALL_D :
                    (BLOCK_TYPE == `BLK_MEDIUM) ? `MED_D : `LARGE_D;
  localparam DAW  = (BLOCK_TYPE == `BLK_SMALL)  ? `SMALL_DAW :
                    (BLOCK_TYPE == `BLK_MEDIUM) ? `MED_DAW : `LARGE_DAW;
  localparam DW   = (W / 9) * 8;  // Data bits without parity
  localparam [16:0] D17 = D;      // Native depth at fill-counter width
  localparam [`WCODE_W-1:0] NSHAPE =
                    (BLOCK_TYPE == `BLK_SMALL)  ? `SMALL_NSHAPE :
                    (BLOCK_TYPE == `BLK_MEDIUM) ? `MED_NSHAPE : `LARGE_NSHAPE;

  // ****************************************
  // Functions
  // ****************************************
  // Element width for a width code
  function [7:0] shape_w;
    input [`WCODE_W-1:0] c;
    begin
      if (c >= NSHAPE) begin
        shape_w = 8'h00;
      end else if (BLOCK_TYPE == `BLK_LARGE) begin
        case (c)
          4'h0:    shape_w = 8'd8;
          4'h1:    shape_w = 8'd9;
          4'h2:    shape_w = 8'd16;
          4'h3:    shape_w = 8'd18;
          4'h4:    shape_w = 8'd32;
          4'h5:    shape_w = 8'd36;
          4'h6:    shape_w = 8'd64;
          4'h7:    shape_w = 8'd72;
          default: shape_w = 8'd128;
        endcase
      end else begin
        case (c)
          4'h0:    shape_w = 8'd1;
          4'h1:    shape_w = 8'd2;
          4'h2:    shape_w = 8'd4;
          4'h3:    shape_w = 8'd8;
          4'h4:    shape_w = 8'd9;
          4'h5:    shape_w = 8'd16;
          4'h6:    shape_w = 8'd18;
          4'h7:    shape_w = 8'd32;
          default: shape_w = 8'd36;
        endcase
      end
    end
  endfunction

  // Widths that are multiples of nine carry parity bits
  function is_par;
    input [7:0] k;
    begin
      is_par = (k != 8'h00) && ((k % 9) == 0);
    end
  endfunction

  // Log2 of elements per native word
  function [4:0] shift_of;
    input [7:0] k;
    integer j;
    integer base;
    begin
      base = is_par(k) ? W : DW;
      shift_of = 5'h00;
      for (j = 0; j < 8; j = j + 1) begin
        if ((k << j) == base) begin
          shift_of = j[4:0];
        end
      end
    end
  endfunction

  // Physical bit of element bit i; data-only shapes skip parity bits
  function integer phys;
    input [7:0]   k;
    input integer e;
    input integer i;
    integer j;
    begin
      j = e * k + i;
      phys = is_par(k) ? j : (j / 8) * 9 + (j % 8);
    end
  endfunction

  // Place element value into its native-word bit positions
  function [W-1:0] spread;
    input [7:0]   k;
    input integer e;
    input [W-1:0] v;
    integer i;
    begin
      spread = {W{1'b0}};
      for (i = 0; i < W; i = i + 1) begin
        if (i < k) begin
          spread[phys(k, e, i)] = v[i];
        end
      end
    end
  endfunction

  // Pull an element out of a native word, upper bits zero
  function [W-1:0] gather;
    input [7:0]   k;
    input integer e;
    input [W-1:0] word;
    integer i;
    begin
      gather = {W{1'b0}};
      for (i = 0; i < W; i = i + 1) begin
        if (i < k) begin
          gather[i] = word[phys(k, e, i)];
        end
      end
    end
  endfunction

  // ****************************************
  // Signals
  // ****************************************
  reg  [2:0]          eff_mode;     // Mode after fallback
  reg                 mode_bad;     // Mode unknown or unsupported
  wire                is_fifo;      // FIFO mode active
  wire [`WCODE_W-1:0] code_b;       // Width code used on port B
  reg  [7:0]          k_a, k_b;     // Element widths
  reg  [4:0]          s_a, s_b;     // Elements-per-word shifts
  reg  [`ADDR_W-1:0]  ea_a, ea_b;   // Effective element addresses
  reg  [`ADDR_W-1:0]  tw_a, tw_b;   // Shifted addresses
  reg  [DAW-1:0]      word_a;       // Native word index A
  reg  [DAW-1:0]      word_b;       // Native word index B
  reg  [15:0]         el_a, el_b;   // Element index in word
  reg  [16:0]         depth;        // FIFO depth in elements
  reg                 a_we, a_re;   // Port A strobes
  reg                 b_we, b_re;   // Port B strobes
  wire [W-1:0]        q_a, q_b;     // Array words
  reg  [W-1:0]        dout_a_reg;   // Output register A
  reg  [W-1:0]        dout_b_reg;   // Output register B
  reg  [W-1:0]        dout_a_next;
  reg  [W-1:0]        dout_b_next;
  reg  [15:0]         wr_ptr_reg;   // FIFO write element pointer
  reg  [15:0]         rd_ptr_reg;   // FIFO read element pointer
  reg  [16:0]         cnt_reg;      // FIFO fill in elements
  reg                 cfg_err_reg;  // Registered configuration error
  wire                push, pop;    // FIFO moves

  // ****************************************
  // Mode decode
  // ****************************************
  // Small block has no true dual-port; it behaves as simple
  // Large block has no ROM use; flagged and idle
  always @* begin
    eff_mode = mode_sel;
    mode_bad = 1'b0;
    case (mode_sel)
      `MODE_SINGLE, `MODE_SIMPLE, `MODE_FIFO: mode_bad = 1'b0;
      `MODE_TRUE: begin
        if (BLOCK_TYPE == `BLK_SMALL) begin
          eff_mode = `MODE_SIMPLE;
          mode_bad = 1'b1;
        end
      end
      `MODE_ROM:  mode_bad = (BLOCK_TYPE == `BLK_LARGE);
      default:    mode_bad = 1'b1;
    endcase
  end

  assign is_fifo = (eff_mode == `MODE_FIFO);
  // FIFO uses port A's shape on both sides; else port B uses width_b
  assign code_b  = is_fifo ? width_a : width_b;

  // ****************************************
  // Address decode
  // ****************************************
  // Element address splits into word index and element slot
  always @* begin
    k_a    = shape_w(width_a);
    k_b    = shape_w(code_b);
    s_a    = shift_of(k_a);
    s_b    = shift_of(k_b);
    ea_a   = is_fifo ? wr_ptr_reg : addr_a;
    ea_b   = is_fifo ? rd_ptr_reg : addr_b;
    tw_a   = ea_a >> s_a;
    tw_b   = ea_b >> s_b;
    word_a = tw_a[DAW-1:0];
    word_b = tw_b[DAW-1:0];
    el_a   = ea_a & ((16'h0001 << s_a) - 16'h0001);
    el_b   = ea_b & ((16'h0001 << s_b) - 16'h0001);
    depth  = D17 << s_a;
  end

  // ****************************************
  // Port strobes
  // ****************************************
  assign push = is_fifo && wen_a && (cnt_reg != depth) && (k_a != 8'h00);
  assign pop  = is_fifo && ren_b && (cnt_reg != 17'h00000) && (k_a != 8'h00);

  // Writes and reads allowed per mode
  always @* begin
    a_we = 1'b0;
    a_re = 1'b0;
    b_we = 1'b0;
    b_re = 1'b0;
    if (!mode_bad || (mode_sel == `MODE_TRUE)) begin
      case (eff_mode)
        `MODE_SINGLE: begin
          a_we = wen_a;
          a_re = ren_a;
        end
        `MODE_SIMPLE: begin
          a_we = wen_a;
          b_re = ren_b;
        end
        `MODE_TRUE: begin
          a_we = wen_a;
          a_re = ren_a;
          b_we = wen_b;
          b_re = ren_b;
        end
        `MODE_ROM: begin
          a_re = ren_a;
          b_re = ren_b;
        end
        `MODE_FIFO: begin
          a_we = push;
          b_re = pop;
        end
        default: begin
          a_we = 1'b0;
        end
      endcase
    end
    // Illegal width codes disable that port
    if (k_a == 8'h00) begin
      a_we = 1'b0;
      a_re = 1'b0;
    end
    if (k_b == 8'h00) begin
      b_we = 1'b0;
      b_re = 1'b0;
    end
  end

  // ****************************************
  // Storage
  // ****************************************
  ram_array #(
    .W   (W),
    .D   (D),
    .DAW (DAW)
  ) u_array (
    .clk     (sys_clk),
    .we_a    (a_we),
    .addr_a  (word_a),
    .wmask_a (spread(k_a, el_a, {W{1'b1}})),
    .wdata_a (spread(k_a, el_a, din_a)),
    .q_a     (q_a),
    .we_b    (b_we),
    .addr_b  (word_b),
    .wmask_b (spread(k_b, el_b, {W{1'b1}})),
    .wdata_b (spread(k_b, el_b, din_b)),
    .q_b     (q_b)
  );

  // ****************************************
  // Output registers
  // ****************************************
  // Clear beats a read in the same cycle
  always @* begin
    dout_a_next = dout_a_reg;
    dout_b_next = dout_b_reg;
    if (clr_a) begin
      dout_a_next = {W{1'b0}};
    end else if (a_re) begin
      dout_a_next = gather(k_a, el_a, q_a);
    end
    if (clr_b) begin
      dout_b_next = {W{1'b0}};
    end else if (b_re) begin
      dout_b_next = gather(k_b, el_b, q_b);
    end
  end

  // Large outputs power up unknown; the others reset to zero
  generate
    if (BLOCK_TYPE == `BLK_LARGE) begin : g_out_nores
      always @(posedge sys_clk) begin
        dout_a_reg <= dout_a_next;
        dout_b_reg <= dout_b_next;
      end
    end else begin : g_out_res
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          dout_a_reg <= {W{1'b0}};
          dout_b_reg <= {W{1'b0}};
        end else begin
          dout_a_reg <= dout_a_next;
          dout_b_reg <= dout_b_next;
        end
      end
    end
  endgenerate

  // ****************************************
  // FIFO pointers and status
  // ****************************************
  // Pointers wrap at the shape depth; cleared outside FIFO mode
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg  <= 16'h0000;
      rd_ptr_reg  <= 16'h0000;
      cnt_reg     <= 17'h00000;
      cfg_err_reg <= 1'b0;
    end else begin
      cfg_err_reg <= mode_bad || (k_a == 8'h00) || (k_b == 8'h00);
      if (!is_fifo) begin
        wr_ptr_reg <= 16'h0000;
        rd_ptr_reg <= 16'h0000;
        cnt_reg    <= 17'h00000;
      end else begin
        if (push) begin
          wr_ptr_reg <= (wr_ptr_reg + 16'h0001) & (depth[15:0] - 16'h0001);
        end
        if (pop) begin
          rd_ptr_reg <= (rd_ptr_reg + 16'h0001) & (depth[15:0] - 16'h0001);
        end
        if (push && !pop) begin
          cnt_reg <= cnt_reg + 17'h00001;
        end else if (pop && !push) begin
          cnt_reg <= cnt_reg - 17'h00001;
        end
      end
    end
  end

  assign dout_a     = dout_a_reg;
  assign dout_b     = dout_b_reg;
  assign fifo_full  = is_fifo && (cnt_reg == depth);
  assign fifo_empty = !is_fifo || (cnt_reg == 17'h00000);
  assign cfg_err    = cfg_err_reg;

endmodule // configurable_embedded_ram

// file: hdl/embedded_ram_consts.vh
// Constants for the configurable embedded RAM: block types, native
// geometry, port modes and width-code counts.
// Assumes it is included by bare name by the RAM design files.
`ifndef EMBEDDED_RAM_CONSTS_VH
`define EMBEDDED_RAM_CONSTS_VH

// ****************************************
// Block types
// ****************************************
`define BLK_SMALL   2'h0
`define BLK_MEDIUM  2'h1
`define BLK_LARGE   2'h2

// ****************************************
// Native geometry per block type
// ****************************************
`define SMALL_W     18
`define SMALL_D     32
`define SMALL_DAW   5
`define MED_W       36
`define MED_D       128
`define MED_DAW     7
`define LARGE_W     144
`define LARGE_D     4096
`define LARGE_DAW   12
// Native word width for a block type code
`define NATIVE_W(t) (((t) == `BLK_SMALL) ? `SMALL_W : ((t) == `BLK_MEDIUM) ? `MED_W : `LARGE_W)

// Number of legal width codes per block type
`define SMALL_NSHAPE  4'h7
`define MED_NSHAPE    4'h9
`define LARGE_NSHAPE  4'h9

// ****************************************
// Port modes
// ****************************************
`define MODE_SINGLE 3'h0
`define MODE_SIMPLE 3'h1
`define MODE_TRUE   3'h2
`define MODE_ROM    3'h3
`define MODE_FIFO   3'h4

// Port field widths
`define ADDR_W      16
`define WCODE_W     4

`endif

// file: hdl/ram_array.v
// Flip-flop storage array with two word-wide ports and bit write masks.
// Assumes both ports run on one clock; reads are combinational.
`timescale 1ns/1ps
`include "embedded_ram_consts.vh"

module ram_array #(
  parameter W   = `SMALL_W,
  parameter D   = `SMALL_D,
  parameter DAW = `SMALL_DAW
) (
  // Clock
  input  wire           clk,
  // Port A
  input  wire           we_a,
  input  wire [DAW-1:0] addr_a,
  input  wire [W-1:0]   wmask_a,
  input  wire [W-1:0]   wdata_a,
  output wire [W-1:0]   q_a,
  // Port B
  input  wire           we_b,
  input  wire [DAW-1:0] addr_b,
  input  wire [W-1:0]   wmask_b,
  input  wire [W-1:0]   wdata_b,
  output wire [W-1:0]   q_b
);

  reg  [W-1:0] mem [0:D-1];  // Storage words, not reset
  wire [W-1:0] merged_a;     // Word A after its own write
  wire [W-1:0] base_b;       // Word B seen before B's write

  assign merged_a = (mem[addr_a] & ~wmask_a) | (wdata_a & wmask_a);
  // Same word written by both ports: keep A's bits, B wins overlaps
  assign base_b   = (we_a && (addr_a == addr_b)) ? merged_a : mem[addr_b];

  // Reads return old data during a write to the same word
  assign q_a = mem[addr_a];
  assign q_b = mem[addr_b];

  // ****************************************
  // Write process
  // ****************************************
  always @(posedge clk) begin
    if (we_a) begin
      mem[addr_a] <= merged_a;
    end
    if (we_b) begin
      mem[addr_b] <= (base_b & ~wmask_b) | (wdata_b & wmask_b);
    end
  end

endmodule // ram_array

// file: verif/configurable_embedded_ram_checker.sv
// Port checks for the embedded RAM block.
// Assumes it is bound into configurable_embedded_ram on one clock.
`timescale 1ns/1ps
`include "embedded_ram_consts.vh"

module ram_checker #(
  parameter [1:0] BLOCK_TYPE = `BLK_MEDIUM,
  parameter       W          = (BLOCK_TYPE == `BLK_SMALL) ? `SMALL_W :
                               (BLOCK_TYPE == `BLK_MEDIUM) ? `MED_W : `LARGE_W
) (
  // Clock and reset
  input wire                sys_clk,
  input wire                nrst,
  // Configuration and ports
  input wire [2:0]          mode_sel,
  input wire [`WCODE_W-1:0] width_a,
  input wire [`WCODE_W-1:0] width_b,
  input wire                wen_a,
  input wire                ren_a,
  input wire                clr_a,
  input wire                ren_b,
  input wire                clr_b,
  input wire [W-1:0]        dout_a,
  input wire [W-1:0]        dout_b,
  // Status
  input wire                fifo_full,
  input wire                fifo_empty,
  input wire                cfg_err
);
  // Count of legal width codes for this block size
  localparam NS = (BLOCK_TYPE == `BLK_SMALL) ? 7 : 9;
  // High when mode code is at most MODE_FIFO and both width codes are below NS
  wire legal = (mode_sel <= `MODE_FIFO) && (width_a < NS) && (width_b < NS);

  // ****
  // Assertions
  // ****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_reset_zero: assert property ($rose(nrst) |-> (BLOCK_TYPE == `BLK_LARGE) ||
    (dout_a == '0 && dout_b == '0)) else $error("outputs not zero after reset");
  a_clear_a: assert property (legal && clr_a |=> dout_a == '0)
    else $error("port a clear failed");
  a_clear_b: assert property (legal && clr_b |=> dout_b == '0)
    else $error("port b clear failed");
  a_hold_a: assert property (!ren_a && !clr_a |=> $stable(dout_a))
    else $error("port a output moved");
  a_hold_b: assert property (!ren_b && !clr_b |=> $stable(dout_b))
    else $error("port b output moved");
  a_flags_idle: assert property (mode_sel != `MODE_FIFO |-> fifo_empty && !fifo_full)
    else $error("fifo flags wrong outside fifo mode");
  a_bad_mode: assert property (mode_sel > `MODE_FIFO |=> cfg_err)
    else $error("illegal mode not flagged");
  a_bad_width: assert property (mode_sel == `MODE_SINGLE && width_a >= NS |=> cfg_err)
    else $error("illegal width not flagged");
  a_good_cfg: assert property (legal && mode_sel <= `MODE_TRUE &&
    !(BLOCK_TYPE == `BLK_SMALL && mode_sel == `MODE_TRUE) |=> !cfg_err)
    else $error("legal setup flagged");
  a_fifo_push: assert property ((mode_sel == `MODE_FIFO && legal && fifo_empty && wen_a)
    ##1 (mode_sel == `MODE_FIFO) |-> !fifo_empty) else $error("push left fifo empty");

  // Main scenarios reached
  c_push: cover property (mode_sel == `MODE_FIFO && wen_a && fifo_empty);
  c_clr_rd: cover property (clr_b && ren_b);
  c_tdp: cover property (mode_sel == `MODE_TRUE && wen_a);
endmodule // ram_checker

bind configurable_embedded_ram ram_checker #(.BLOCK_TYPE(BLOCK_TYPE)) u_ram_checker (
  .sys_clk, .nrst, .mode_sel, .width_a, .width_b, .wen_a, .ren_a, .clr_a, .ren_b,
  .clr_b, .dout_a, .dout_b, .fifo_full, .fifo_empty, .cfg_err);

// file: verif/fabric_user.sv
// Model of the user logic that drives the RAM block's ports.
// Assumes a 36-bit native port; drives on the falling edge.
`timescale 1ns/1ps

module fabric_user (
  // Clock
  input wire         sys_clk,
  // Configuration
  output reg [2:0]   mode_sel,
  output reg [3:0]   width_a,
  output reg [3:0]   width_b,
  // Port A
  output reg [15:0]  addr_a,
  output reg         wen_a,
  output reg         ren_a,
  output reg         clr_a,
  output reg [35:0]  din_a,
  // Port B
  output reg [15:0]  addr_b,
  output reg         wen_b,
  output reg         ren_b,
  output reg         clr_b,
  output reg [35:0]  din_b
);
  // Everything idle from time zero
  initial begin
    {mode_sel, width_a, width_b} = 11'h000;
    {addr_a, wen_a, ren_a, clr_a, din_a} = 55'h0;
    {addr_b, wen_b, ren_b, clr_b, din_b} = 55'h0;
  end

  // Set mode and width codes
  task cfg(input [2:0] m, input [3:0] wa, input [3:0] wb);
    begin
      @(negedge sys_clk);
      mode_sel = m;
      width_a = wa;
      width_b = wb;
    end
  endtask

  // One cycle on both ports; control is {clear, read, write}
  task drive(input [2:0] ca, input [15:0] aa, input [35:0] da,
             input [2:0] cb, input [15:0] ab, input [35:0] db);
    begin
      @(negedge sys_clk);
      {clr_a, ren_a, wen_a} = ca;
      addr_a = aa;
      // Data not being written is scrambled, never left stale
      din_a = ca[0] ? da : ~din_a;
      {clr_b, ren_b, wen_b} = cb;
      addr_b = ab;
      din_b = cb[0] ? db : ~din_b;
    end
  endtask
endmodule // fabric_user

// file: verif/configurable_embedded_ram_tb_top.sv
// Self-checking bench for the medium-size RAM block.
// Assumes the checker is bound in and fabric_user drives the ports.
`timescale 1ns/1ps

module configurable_embedded_ram_tb_top;
  reg         sys_clk;
  reg         nrst;
  wire [2:0]  mode_sel;
  wire [3:0]  width_a, width_b;
  wire [15:0] addr_a, addr_b;
  wire        wen_a, ren_a, clr_a, wen_b, ren_b, clr_b;
  wire [35:0] din_a, din_b, dout_a, dout_b;
  wire        fifo_full, fifo_empty, cfg_err;
  int         errors = 0;
  int         check_count = 0;
  int         wd [9] = '{1, 2, 4, 8, 9, 16, 18, 32, 36};

  fabric_user u_fabric_user (.sys_clk, .mode_sel, .width_a, .width_b, .addr_a, .wen_a,
    .ren_a, .clr_a, .din_a, .addr_b, .wen_b, .ren_b, .clr_b, .din_b);
  configurable_embedded_ram #(.BLOCK_TYPE(2'h1)) u_configurable_embedded_ram (
    .sys_clk, .nrst, .mode_sel, .width_a, .width_b, .addr_a, .wen_a, .ren_a, .clr_a,
    .din_a, .dout_a, .addr_b, .wen_b, .ren_b, .clr_b, .din_b, .dout_b, .fifo_full,
    .fifo_empty, .cfg_err);

  // ****
  // Helpers
  // ****
  task chk(input string name, input [35:0] seen, input [35:0] exp);
    begin
      check_count++;
      if (seen !== exp) begin
        errors++;
        $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  task idle;
    u_fabric_user.drive(3'h0, 16'h0, 36'h0, 3'h0, 16'h0, 36'h0);
  endtask

  task close_out;
    begin
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask

  // ****
  // Scenarios
  // ****
  task t_reset;
    begin
      chk("dout_a", dout_a, 36'h0);
      chk("dout_b", dout_b, 36'h0);
      chk("cfg_err", cfg_err, 36'h0);
    end
  endtask

  // Byte writes on A, 32-bit read on B
  task t_sdp;
    begin
      u_fabric_user.cfg(3'h1, 4'h3, 4'h7);
      u_fabric_user.drive(3'h1, 16'h0, 36'haa, 3'h0, 16'h0, 36'h0);
      u_fabric_user.drive(3'h1, 16'h1, 36'hbb, 3'h0, 16'h0, 36'h0);
      // Upper bytes written too: storage powers up unknown
      u_fabric_user.drive(3'h1, 16'h2, 36'h00, 3'h0, 16'h0, 36'h0);
      u_fabric_user.drive(3'h1, 16'h3, 36'h00, 3'h0, 16'h0, 36'h0);
      u_fabric_user.drive(3'h0, 16'h0, 36'h0, 3'h2, 16'h0, 36'h0);
      idle;
      chk("mixed read", dout_b, 36'h0000bbaa);
    end
  endtask

  // 36-bit write on A, 9-bit element read on B
  task t_tdp;
    begin
      u_fabric_user.cfg(3'h2, 4'h8, 4'h4);
      u_fabric_user.drive(3'h1, 16'h0, 36'h987654321, 3'h0, 16'h0, 36'h0);
      u_fabric_user.drive(3'h0, 16'h0, 36'h0, 3'h2, 16'h1, 36'h0);
      idle;
      chk("tdp element", dout_b, (36'h987654321 >> 9) & 36'h1ff);
    end
  endtask

  // Every shape of the medium block, then an illegal code
  task t_shapes;
    begin
      for (int k = 0; k < 9; k++) begin
        u_fabric_user.cfg(3'h0, k[3:0], 4'h0);
        u_fabric_user.drive(3'h1, 16'h0, 36'hfffffffff, 3'h0, 16'h0, 36'h0);
        u_fabric_user.drive(3'h2, 16'h0, 36'h0, 3'h0, 16'h0, 36'h0);
        idle;
        chk("shape read", dout_a, (36'h1 << wd[k]) - 36'h1);
        chk("cfg_err", cfg_err, 36'h0);
      end
      u_fabric_user.cfg(3'h0, 4'h9, 4'h0);
      idle;
      chk("cfg_err", cfg_err, 36'h1);
    end
  endtask

  // Clear and read together: clear wins
  task t_clear;
    begin
      u_fabric_user.cfg(3'h1, 4'h8, 4'h8);
      u_fabric_user.drive(3'h0, 16'h0, 36'h0, 3'h6, 16'h0, 36'h0);
      idle;
      chk("cleared", dout_b, 36'h0);
    end
  endtask

  task t_fifo;
    begin
      u_fabric_user.cfg(3'h4, 4'h3, 4'h3);
      u_fabric_user.drive(3'h1, 16'h0, 36'h5a, 3'h0, 16'h0, 36'h0);
      idle;
      chk("fifo_empty", fifo_empty, 36'h0);
      chk("fifo_full", fifo_full, 36'h0);
      u_fabric_user.drive(3'h0, 16'h0, 36'h0, 3'h2, 16'h0, 36'h0);
      idle;
      chk("popped", dout_b, 36'h5a);
      chk("fifo_empty", fifo_empty, 36'h1);
      // Fill to the 128-deep 36-bit shape, then drain one
      u_fabric_user.cfg(3'h4, 4'h8, 4'h8);
      for (int i = 0; i < 128; i++) begin
        u_fabric_user.drive(3'h1, 16'h0, {4'h0, i + 1}, 3'h0, 16'h0, 36'h0);
      end
      idle;
      chk("fifo_full", fifo_full, 36'h1);
      u_fabric_user.drive(3'h0, 16'h0, 36'h0, 3'h2, 16'h0, 36'h0);
      idle;
      chk("popped first", dout_b, 36'h1);
      chk("fifo_full", fifo_full, 36'h0);
    end
  endtask

  // ROM refuses writes; illegal mode is flagged
  task t_rom;
    begin
      u_fabric_user.cfg(3'h1, 4'h8, 4'h8);
      u_fabric_user.drive(3'h1, 16'h2, 36'h123456789, 3'h0, 16'h0, 36'h0);
      u_fabric_user.cfg(3'h3, 4'h8, 4'h8);
      u_fabric_user.drive(3'h1, 16'h2, 36'hfedcba987, 3'h0, 16'h0, 36'h0);
      u_fabric_user.drive(3'h2, 16'h2, 36'h0, 3'h0, 16'h0, 36'h0);
      idle;
      chk("rom read", dout_a, 36'h123456789);
      u_fabric_user.cfg(3'h5, 4'h8, 4'h8);
      idle;
      chk("cfg_err", cfg_err, 36'h1);
    end
  endtask

  // ****
  // Clock, sequence and watchdog
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    nrst = 1'b0;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    t_reset;
    t_sdp;
    t_tdp;
    t_shapes;
    t_clear;
    t_fifo;
    t_rom;
    close_out;
  end

  // Whole run needs well under 400 cycles
  initial begin
    repeat (2000) @(posedge sys_clk);
    errors++;
    close_out;
  end
endmodule // configurable_embedded_ram_tb_top
